// file: inc/pmc_params.svh
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
// entry form: code, reset value, two bytes, writable
`define OPERATION_CONTROL 8'h01, 16'h0080, 1'b0, 1'b1
`define OUTPUT_VOLTAGE_TARGET 8'h21, 16'h007e, 1'b1, 1'b1
`define OUTPUT_VOLTAGE_CEILING 8'h24, 16'h00ff, 1'b1, 1'b1
`define MARGIN_HIGH_LEVEL 8'h25, 16'h0000, 1'b1, 1'b1
`define MARGIN_LOW_LEVEL 8'h26, 16'h0000, 1'b1, 1'b1
`define INPUT_TURN_ON_LEVEL 8'h35, 16'he850, 1'b1, 1'b1
`define INPUT_TURN_OFF_LEVEL 8'h36, 16'he848, 1'b1, 1'b1
`define CURRENT_CAL_GAIN 8'h38, 16'h88a8, 1'b1, 1'b1
`define CURRENT_CAL_OFFSET 8'h39, 16'hf800, 1'b1, 1'b1
`define INPUT_OVERVOLTAGE_LIMIT 8'h55, 16'he870, 1'b1, 1'b1
`define INPUT_UNDERVOLTAGE_WARNING 8'h58, 16'he84c, 1'b1, 1'b1
`define OUTPUT_VOLTAGE_STATUS 8'h7a, 16'h0000, 1'b0, 1'b0
`define OUTPUT_CURRENT_STATUS 8'h7b, 16'h0000, 1'b0, 1'b0
`define INPUT_STATUS 8'h7c, 16'h0000, 1'b0, 1'b0
`define THERMAL_STATUS 8'h7d, 16'h0000, 1'b0, 1'b0
`define INPUT_VOLTAGE_READING 8'h88, 16'he800, 1'b1, 1'b0
`define INPUT_CURRENT_READING 8'h89, 16'he000, 1'b1, 1'b0
`define OUTPUT_VOLTAGE_READING 8'h8b, 16'h0000, 1'b1, 1'b0
`define OUTPUT_CURRENT_READING 8'h8c, 16'hf000, 1'b1, 1'b0
`define TEMPERATURE_READING 8'h8d, 16'h0019, 1'b1, 1'b0
`define OUTPUT_POWER_READING 8'h96, 16'h0000, 1'b1, 1'b0
`define STATE2_SLOPE_SLEW 8'hba, 16'h01c1, 1'b1, 1'b1
`define STATE2_SLOPE_COUNT 8'hbb, 16'h03f0, 1'b1, 1'b1
`define REGULATOR_CONFIG 8'hd0, 16'hec00, 1'b1, 1'b1
`define TEMPERATURE_CONFIG 8'hd1, 16'h500a, 1'b1, 1'b1
`define CURRENT_SENSE_GAIN 8'hd3, 16'h0159, 1'b1, 1'b1
`define OVERCURRENT_SETTING 8'hd4, 16'h4525, 1'b1, 1'b1
`define OVER_UNDER_VOLTAGE_SETTING 8'hd5, 16'h4a54, 1'b1, 1'b1
`define OVERCURRENT_TRIGGER 8'hd6, 16'h002a, 1'b0, 1'b1
`define SERIAL_VID_ADDRESS 8'hd9, 16'h0010, 1'b0, 1'b1
`define OVERTEMP_SETTING 8'hdb, 16'h961e, 1'b1, 1'b1
`define POWER_STATE_TRIM 8'hdc, 16'h0d8b, 1'b1, 1'b1
`define CURRENT_SENSE_OFFSET 8'hdd, 16'h003a, 1'b0, 1'b1
`define BLANKING_TIME 8'he8, 16'h0018, 1'b0, 1'b1
`define BOOT_VOLTAGE 8'hea, 16'h017e, 1'b1, 1'b1
`define MAX_LOAD_CURRENT 8'heb, 16'h00ff, 1'b0, 1'b1
`define MAX_TEMPERATURE 8'hec, 16'h007d, 1'b0, 1'b1
`define SLEW_RATE_SETTING 8'hed, 16'h1405, 1'b1, 1'b1
`define REGULATOR_TOLERANCE 8'hee, 16'h0028, 1'b0, 1'b1
`define CAPABILITY_FLAGS 8'hf5, 16'h007f, 1'b0, 1'b1
`define STEP_SIZE_SETTING 8'hf7, 16'h0022, 1'b0, 1'b1
`define STATE0_SLOPE_SLEW 8'hfa, 16'h00ec, 1'b1, 1'b1
`define STATE0_SLOPE_COUNT 8'hfb, 16'h0034, 1'b0, 1'b1
`define STATE1_SLOPE_COUNT 8'hfc, 16'h020e, 1'b1, 1'b1
`define STATE1_SLOPE_SLEW 8'hfd, 16'h01c9, 1'b1, 1'b1
`define PROTECTION_DISABLE 8'hfe, 16'h3100, 1'b1, 1'b1
// entries referenced by the logic itself
`define SWITCHING_FREQ_SETTING 8'hd2
`define SWITCHING_FREQ_SETTING_RV 16'h00b2
`define MGMT_BUS_ADDRESS 8'hd8
`define MGMT_BUS_ADDRESS_RV 16'h008f
`define SUMMARY_STATUS_BYTE 8'h78
`define SUMMARY_STATUS_WORD 8'h79
`define BUS_COMM_STATUS 8'h7e
`define STATUS_RV 16'h0000
`define MAKER_CODE_CMD 8'hef
`define PART_REVISION_CODE_CMD 8'hf1
`define CONFIG_CODE_LOW_CMD 8'hf2
`define CONFIG_CODE_HIGH_CMD 8'hf3
`define PROTOCOL_CODE_CMD 8'hf4
`define CLEAR_FAULTS_CMD 8'h03
`define STORE_SETTINGS_CMD 8'h15
`define RELOAD_SAVED_SETTINGS_CMD 8'h16
// bus address, fault bits, frequency
`define ADDR_FIXED_HIGH 4'b0100
`define CML_BAD_CMD_BIT 7
`define CML_BAD_DATA_BIT 6
`define CML_OTHER_BIT 1
`define BUS_COMM_STATUS_BIT 1
`define FS_MIN_KHZ 10'd200
`define FS_MAX_KHZ 10'd1000
`define FS_REG_STEP_KHZ 10'd10
`define FS_STRAP_STEP_KHZ 10'd100
`define FS_EDGE1_MV 12'd48
`define FS_EDGE2_MV 12'd132
`define FS_EDGE3_MV 12'd223
`define FS_EDGE4_MV 12'd328
`define FS_EDGE5_MV 12'd429
`define FS_EDGE6_MV 12'd530
`define FS_EDGE7_MV 12'd642
`define FS_EDGE8_MV 12'd942
`endif

// file: inc/pmc_pkg.sv
package pmc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA} pmc_phase_e;
  typedef struct packed {
    logic sup;
    logic send;
    logic wr;
    logic two;
    logic [15:0] rv;
  } pmc_cmd_info_s;
  typedef struct packed {
    pmc_phase_e st;
    logic [3:0] bitcnt;
    logic ack_phase;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic have_cmd;
    logic rd;
    logic [1:0] nbytes;
    logic [15:0] wdata;
    logic sda_low;
    logic [7:0] cml;
    logic alert;
    logic [9:0] fs_khz;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] src_s;
    logic [255:0][15:0] regs;
    logic [255:0][15:0] nv;
  } pmc_state_s;
endpackage

// file: hw/pmc_command_map.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"
module pmc_command_map #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [7:0] PART_REVISION_CODE = 8'h5a,
  parameter logic [7:0] CONFIG_CODE_LOW = 8'h5a,
  parameter logic [7:0] CONFIG_CODE_HIGH = 8'h5a,
  parameter logic [7:0] PROTOCOL_CODE = 8'h5a
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic alert_output_out,
  output logic alert_output_oe,
  input wire logic [11:0] freq_strap_pin_mv,
  input wire logic freq_from_register,
  output logic [9:0] switching_freq_khz,
  output logic [7:0] operation_control
);
  // identity codes above are arbitrary values

  localparam logic [7:0][11:0] STRAP_EDGES = {`FS_EDGE8_MV, `FS_EDGE7_MV, `FS_EDGE6_MV,
    `FS_EDGE5_MV, `FS_EDGE4_MV, `FS_EDGE3_MV, `FS_EDGE2_MV, `FS_EDGE1_MV};

  function automatic pmc_pkg::pmc_cmd_info_s merge(input pmc_pkg::pmc_cmd_info_s r,
      input logic [7:0] c, input logic [7:0] code, input logic [15:0] rv,
      input logic two, input logic wr);
    merge = r;
    if (c == code) begin
      merge.sup = 1'b1;
      merge.send = 1'b0;
      merge.wr = wr;
      merge.two = two;
      merge.rv = rv;
    end
  endfunction

  function automatic pmc_pkg::pmc_cmd_info_s info_of(input logic [7:0] c);
    pmc_pkg::pmc_cmd_info_s r;
    r = '0;
    r = merge(r, c, `OPERATION_CONTROL);
    r = merge(r, c, `OUTPUT_VOLTAGE_TARGET);
    r = merge(r, c, `OUTPUT_VOLTAGE_CEILING);
    r = merge(r, c, `MARGIN_HIGH_LEVEL);
    r = merge(r, c, `MARGIN_LOW_LEVEL);
    r = merge(r, c, `INPUT_TURN_ON_LEVEL);
    r = merge(r, c, `INPUT_TURN_OFF_LEVEL);
    r = merge(r, c, `CURRENT_CAL_GAIN);
    r = merge(r, c, `CURRENT_CAL_OFFSET);
    r = merge(r, c, `INPUT_OVERVOLTAGE_LIMIT);
    r = merge(r, c, `INPUT_UNDERVOLTAGE_WARNING);
    r = merge(r, c, `SUMMARY_STATUS_BYTE, `STATUS_RV, 1'b0, 1'b0);
    r = merge(r, c, `SUMMARY_STATUS_WORD, `STATUS_RV, 1'b1, 1'b0);
    r = merge(r, c, `OUTPUT_VOLTAGE_STATUS);
    r = merge(r, c, `OUTPUT_CURRENT_STATUS);
    r = merge(r, c, `INPUT_STATUS);
    r = merge(r, c, `THERMAL_STATUS);
    r = merge(r, c, `BUS_COMM_STATUS, `STATUS_RV, 1'b0, 1'b0);
    r = merge(r, c, `INPUT_VOLTAGE_READING);
    r = merge(r, c, `INPUT_CURRENT_READING);
    r = merge(r, c, `OUTPUT_VOLTAGE_READING);
    r = merge(r, c, `OUTPUT_CURRENT_READING);
    r = merge(r, c, `TEMPERATURE_READING);
    r = merge(r, c, `OUTPUT_POWER_READING);
    r = merge(r, c, `STATE2_SLOPE_SLEW);
    r = merge(r, c, `STATE2_SLOPE_COUNT);
    r = merge(r, c, `REGULATOR_CONFIG);
    r = merge(r, c, `TEMPERATURE_CONFIG);
    r = merge(r, c, `SWITCHING_FREQ_SETTING, `SWITCHING_FREQ_SETTING_RV, 1'b0, 1'b1);
    r = merge(r, c, `CURRENT_SENSE_GAIN);
    r = merge(r, c, `OVERCURRENT_SETTING);
    r = merge(r, c, `OVER_UNDER_VOLTAGE_SETTING);
    r = merge(r, c, `OVERCURRENT_TRIGGER);
    r = merge(r, c, `MGMT_BUS_ADDRESS, `MGMT_BUS_ADDRESS_RV, 1'b0, 1'b1);
    r = merge(r, c, `SERIAL_VID_ADDRESS);
    r = merge(r, c, `OVERTEMP_SETTING);
    r = merge(r, c, `POWER_STATE_TRIM);
    r = merge(r, c, `CURRENT_SENSE_OFFSET);
    r = merge(r, c, `BLANKING_TIME);
    r = merge(r, c, `BOOT_VOLTAGE);
    r = merge(r, c, `MAX_LOAD_CURRENT);
    r = merge(r, c, `MAX_TEMPERATURE);
    r = merge(r, c, `SLEW_RATE_SETTING);
    r = merge(r, c, `REGULATOR_TOLERANCE);
    r = merge(r, c, `MAKER_CODE_CMD, {8'h00, MAKER_CODE}, 1'b0, 1'b1);
    r = merge(r, c, `PART_REVISION_CODE_CMD, {8'h00, PART_REVISION_CODE}, 1'b0, 1'b1);
    r = merge(r, c, `CONFIG_CODE_LOW_CMD, {8'h00, CONFIG_CODE_LOW}, 1'b0, 1'b1);
    r = merge(r, c, `CONFIG_CODE_HIGH_CMD, {8'h00, CONFIG_CODE_HIGH}, 1'b0, 1'b1);
    r = merge(r, c, `PROTOCOL_CODE_CMD, {8'h00, PROTOCOL_CODE}, 1'b0, 1'b1);
    r = merge(r, c, `CAPABILITY_FLAGS);
    r = merge(r, c, `STEP_SIZE_SETTING);
    r = merge(r, c, `STATE0_SLOPE_SLEW);
    r = merge(r, c, `STATE0_SLOPE_COUNT);
    r = merge(r, c, `STATE1_SLOPE_COUNT);
    r = merge(r, c, `STATE1_SLOPE_SLEW);
    r = merge(r, c, `PROTECTION_DISABLE);
    if (c == `CLEAR_FAULTS_CMD || c == `STORE_SETTINGS_CMD
        || c == `RELOAD_SAVED_SETTINGS_CMD) begin
      r.sup = 1'b1;
      r.send = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [9:0] strap_khz(input logic [11:0] mv);
    logic [9:0] k;
    k = `FS_MIN_KHZ;
    for (int i = 0; i < 8; i++) begin
      if (mv >= STRAP_EDGES[i]) begin
        k = k + `FS_STRAP_STEP_KHZ;
      end
    end
    return k;
  endfunction

  function automatic logic [9:0] reg_khz(input logic [7:0] code);
    logic [11:0] p;
    p = 12'(code) * 12'(`FS_REG_STEP_KHZ);
    if (p < 12'(`FS_MIN_KHZ)) begin
      return `FS_MIN_KHZ;
    end else if (p > 12'(`FS_MAX_KHZ)) begin
      return `FS_MAX_KHZ;
    end
    return p[9:0];
  endfunction

  function automatic pmc_pkg::pmc_state_s init_state();
    pmc_pkg::pmc_state_s s;
    pmc_pkg::pmc_cmd_info_s e;
    s = '0;
    s.st = pmc_pkg::ST_IDLE;
    s.fs_khz = `FS_MIN_KHZ;
    // synchronisers start at the idle bus level, so no false edge follows reset
    s.scl_s = 3'b111;
    s.sda_s = 3'b111;
    for (int i = 0; i < 256; i++) begin
      e = info_of(8'(i));
      s.regs[i] = e.rv;
      s.nv[i] = s.regs[i];
    end
    return s;
  endfunction

  localparam pmc_pkg::pmc_state_s RESET_STATE = init_state();

  pmc_pkg::pmc_state_s q;
  pmc_pkg::pmc_state_s n;
  pmc_pkg::pmc_cmd_info_s cinfo;
  pmc_pkg::pmc_cmd_info_s binfo;
  pmc_pkg::pmc_cmd_info_s rinfo;
  logic scl_rise;
  logic scl_fall;
  logic scl_hi;
  logic start_seen;
  logic stop_seen;
  logic do_clear;
  logic [7:0] set_cml;
  logic [1:0] width;
  logic [7:0] sbyte;
  logic [15:0] rword;
  logic [7:0] next_byte;

  always_comb begin
    n = q;
    rinfo = '0;
    set_cml = 8'h00;
    do_clear = 1'b0;
    n.scl_s = {q.scl_s[1:0], scl_in};
    n.sda_s = {q.sda_s[1:0], sda_in};
    n.src_s = {q.src_s[0], freq_from_register};
    scl_rise = q.scl_s[1] & ~q.scl_s[2];
    scl_fall = ~q.scl_s[1] & q.scl_s[2];
    scl_hi = q.scl_s[1] & q.scl_s[2];
    start_seen = scl_hi & q.sda_s[2] & ~q.sda_s[1];
    stop_seen = scl_hi & ~q.sda_s[2] & q.sda_s[1];
    cinfo = info_of(q.cmd);
    binfo = info_of(q.shreg);
    width = cinfo.two ? 2'd2 : 2'd1;
    sbyte = 8'h00;
    sbyte[`BUS_COMM_STATUS_BIT] = |q.cml;
    case (q.cmd)
      `SUMMARY_STATUS_BYTE: rword = {8'h00, sbyte};
      `SUMMARY_STATUS_WORD: rword = {8'h00, sbyte};
      `BUS_COMM_STATUS: rword = {8'h00, q.cml};
      default: rword = q.regs[q.cmd];
    endcase
    if (q.nbytes >= width) begin
      next_byte = 8'hff;
    end else if (q.nbytes == 2'd0) begin
      next_byte = rword[7:0];
    end else begin
      next_byte = rword[15:8];
    end
    // frequency source selection
    if (q.src_s[1]) begin
      n.fs_khz = reg_khz(q.regs[`SWITCHING_FREQ_SETTING][7:0]);
    end else begin
      n.fs_khz = strap_khz(freq_strap_pin_mv);
    end
    // bit engine
    if (scl_rise && q.st != pmc_pkg::ST_IDLE) begin
      if (q.bitcnt < 4'd8) begin
        n.bitcnt = q.bitcnt + 4'd1;
        if (q.st != pmc_pkg::ST_RDATA) begin
          n.shreg = {q.shreg[6:0], q.sda_s[1]};
        end
      end else if (q.st == pmc_pkg::ST_RDATA && !q.ack_phase) begin
        n.nbytes = (q.nbytes == 2'd3) ? q.nbytes : q.nbytes + 2'd1;
        if (q.sda_s[1]) begin
          n.st = pmc_pkg::ST_IDLE;
        end else begin
          n.ack_phase = 1'b1;
        end
      end
    end
    if (scl_fall && q.st != pmc_pkg::ST_IDLE) begin
      if (q.ack_phase) begin
        n.ack_phase = 1'b0;
        n.bitcnt = 4'd0;
        n.sda_low = 1'b0;
        if (q.st == pmc_pkg::ST_RDATA) begin
          if (q.nbytes >= width) begin
            set_cml[`CML_BAD_DATA_BIT] = 1'b1;
          end
          n.shreg = next_byte;
          n.sda_low = ~next_byte[7];
        end
      end else if (q.st == pmc_pkg::ST_RDATA) begin
        if (q.bitcnt == 4'd8) begin
          n.sda_low = 1'b0;
        end else if (q.bitcnt != 4'd0) begin
          n.shreg = {q.shreg[6:0], 1'b0};
          n.sda_low = ~q.shreg[6];
        end
      end else if (q.bitcnt == 4'd8) begin
        n.ack_phase = 1'b1;
        n.sda_low = 1'b1;
        case (q.st)
          pmc_pkg::ST_ADDR: begin
            if (q.shreg[7:1] != {`ADDR_FIXED_HIGH, q.regs[`MGMT_BUS_ADDRESS][2:0]}) begin
              n.st = pmc_pkg::ST_IDLE;
              n.ack_phase = 1'b0;
              n.sda_low = 1'b0;
            end else if (!q.shreg[0]) begin
              n.st = pmc_pkg::ST_CMD;
              n.have_cmd = 1'b0;
            end else if (q.have_cmd && !cinfo.send) begin
              n.st = pmc_pkg::ST_RDATA;
              n.rd = 1'b1;
              n.nbytes = 2'd0;
            end else begin
              set_cml[`CML_OTHER_BIT] = 1'b1;
              n.st = pmc_pkg::ST_IDLE;
              n.have_cmd = 1'b0;
              n.ack_phase = 1'b0;
              n.sda_low = 1'b0;
            end
          end
          pmc_pkg::ST_CMD: begin
            if (!binfo.sup) begin
              set_cml[`CML_BAD_CMD_BIT] = 1'b1;
              n.st = pmc_pkg::ST_IDLE;
              n.ack_phase = 1'b0;
              n.sda_low = 1'b0;
            end else begin
              n.cmd = q.shreg;
              n.have_cmd = 1'b1;
              n.nbytes = 2'd0;
              n.st = pmc_pkg::ST_WDATA;
            end
          end
          pmc_pkg::ST_WDATA: begin
            if (cinfo.send || q.nbytes >= width) begin
              set_cml[`CML_BAD_DATA_BIT] = 1'b1;
              n.st = pmc_pkg::ST_IDLE;
              n.have_cmd = 1'b0;
              n.ack_phase = 1'b0;
              n.sda_low = 1'b0;
            end else begin
              if (q.nbytes == 2'd0) begin
                n.wdata[7:0] = q.shreg;
              end else begin
                n.wdata[15:8] = q.shreg;
              end
              n.nbytes = q.nbytes + 2'd1;
            end
          end
          default: begin
            n.st = pmc_pkg::ST_IDLE;
          end
        endcase
      end
    end
    // transaction end
    if (stop_seen) begin
      if (q.have_cmd && !q.rd) begin
        if (cinfo.send) begin
          if (q.cmd == `CLEAR_FAULTS_CMD) begin
            do_clear = 1'b1;
          end else if (q.cmd == `STORE_SETTINGS_CMD) begin
            n.nv = q.regs;
          end else begin
            for (int i = 0; i < 256; i++) begin
              rinfo = info_of(8'(i));
              if (rinfo.wr) begin
                n.regs[i] = q.nv[i];
              end
            end
          end
        end else if (q.nbytes == width && cinfo.wr) begin
          n.regs[q.cmd] = cinfo.two ? q.wdata : {8'h00, q.wdata[7:0]};
        end else begin
          set_cml[`CML_BAD_DATA_BIT] = 1'b1;
        end
      end
      if (q.rd && q.nbytes < width) begin
        set_cml[`CML_BAD_DATA_BIT] = 1'b1;
      end
      n.st = pmc_pkg::ST_IDLE;
      n.have_cmd = 1'b0;
      n.rd = 1'b0;
      n.ack_phase = 1'b0;
      n.sda_low = 1'b0;
      n.bitcnt = 4'd0;
    end
    if (start_seen) begin
      n.st = pmc_pkg::ST_ADDR;
      n.rd = 1'b0;
      n.ack_phase = 1'b0;
      n.sda_low = 1'b0;
      n.bitcnt = 4'd0;
    end
    // a fault raised in the clearing cycle survives the clear
    n.cml = (do_clear ? 8'h00 : q.cml) | set_cml;
    n.alert = |n.cml;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = q.sda_low;
  assign alert_output_out = 1'b0;
  assign alert_output_oe = q.alert;
  assign switching_freq_khz = q.fs_khz;
  assign operation_control = q.regs[8'h01][7:0];
endmodule
`default_nettype wire

// file: testbench/pmc_command_map_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module pmc_command_map_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic alert_output_out,
  input wire logic alert_output_oe,
  input wire logic [11:0] freq_strap_pin_mv,
  input wire logic freq_from_register,
  input wire logic [9:0] switching_freq_khz,
  input wire logic [7:0] operation_control
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence strap_held;
    (!freq_from_register && $stable(freq_strap_pin_mv)) [*6];
  endsequence
  open_drain_a: assert property (!sda_out && !alert_output_out)
    else $error("open drain output driven high");
  reset_values_a: assert property (disable iff (1'b0) rst |=> operation_control == 8'h80
    && !alert_output_oe && !sda_oe && switching_freq_khz == 10'd200)
    else $error("wrong value after reset");
  freq_range_a: assert property (switching_freq_khz inside {[10'd200:10'd1000]})
    else $error("frequency out of range");
  freq_step_a: assert property (switching_freq_khz % 10 == 0)
    else $error("frequency not on a 10 kHz step");
  strap_band_a: assert property (strap_held |-> switching_freq_khz % 100 == 0)
    else $error("strap frequency not on a band");
  strap_low_a: assert property (strap_held ##0 freq_strap_pin_mv == 12'd0
    |-> switching_freq_khz == 10'd200)
    else $error("zero strap not 200 kHz");
  strap_top_a: assert property (strap_held ##0 freq_strap_pin_mv >= 12'd1181
    |-> switching_freq_khz == 10'd1000)
    else $error("top strap not 1000 kHz");
  opctl_at_stop_a: assert property ($changed(operation_control) |-> scl_in && sda_in)
    else $error("operation control changed inside a transfer");
  alert_clear_a: assert property ($fell(alert_output_oe) |-> scl_in && sda_in)
    else $error("alert released inside a transfer");
  cover property ($rose(alert_output_oe));
  cover property ($changed(operation_control));
  cover property (strap_held ##0 switching_freq_khz == 10'd1000);
endmodule
bind pmc_command_map pmc_command_map_asserts pmc_command_map_asserts_i (.clk_sys(clk_sys),
  .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .alert_output_out(alert_output_out), .alert_output_oe(alert_output_oe),
  .freq_strap_pin_mv(freq_strap_pin_mv), .freq_from_register(freq_from_register),
  .switching_freq_khz(switching_freq_khz), .operation_control(operation_control));
`default_nettype wire

// file: testbench/pmc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmc_host_model (
  input wire logic clk_sys,
  input wire logic sda_w,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic put_bit(input logic b);
    sda_low = !b;
    cyc(2);
    scl = 1'b1;
    cyc(4);
    scl = 1'b0;
    cyc(2);
  endtask
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    cyc(2);
    scl = 1'b1;
    cyc(2);
    b = sda_w;
    cyc(2);
    scl = 1'b0;
    cyc(2);
  endtask
  task automatic start();
    sda_low = 1'b0;
    cyc(2);
    scl = 1'b1;
    cyc(4);
    sda_low = 1'b1;
    cyc(4);
    scl = 1'b0;
    cyc(2);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    cyc(2);
    scl = 1'b1;
    cyc(4);
    sda_low = 1'b0;
    cyc(4);
  endtask
  task automatic put_byte(input logic [7:0] v, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(a);
    ok = ok && !a;
  endtask
  task automatic get_byte(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(last);
  endtask
  // words go low byte first; the last read byte is refused
  task automatic xfer(input logic [6:0] ad, input logic [7:0] c, input int n, input logic rd,
      inout logic [15:0] d, output logic ok);
    ok = 1'b1;
    start();
    put_byte({ad, 1'b0}, ok);
    put_byte(c, ok);
    if (rd) begin
      start();
      put_byte({ad, 1'b1}, ok);
      for (int i = 0; i < n; i++) get_byte(d[8*i+:8], i == n - 1);
    end else begin
      for (int i = 0; i < n; i++) put_byte(d[8*i+:8], ok);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// file: testbench/pmc_command_map_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pmc_command_map_tb;
  logic clk_sys, rst, scl, host_low, sda_w, ffr, sda_out, sda_oe, alert_out, alert_oe, ack;
  logic [11:0] strap_mv;
  logic [9:0] freq;
  logic [7:0] opctl, c;
  logic [15:0] d, v;
  logic [6:0] dev_ad;
  int failures, n_compared, seed, n;
  logic [15:0] mem [logic [7:0]];
  // {read-only, one byte} nibble, code, reset value
  localparam logic [27:0] TBL [27] = '{28'h1010080, 28'h021007e, 28'h02400ff, 28'h0250000,
    28'h0260000, 28'h035e850, 28'h036e848, 28'h03888a8, 28'h039f800, 28'h055e870, 28'h058e84c,
    28'h1d200b2, 28'h1d90010, 28'h0fe3100, 28'h0ea017e, 28'h1f70022, 28'h1f5007f, 28'h0fa00ec,
    28'h1fb0034, 28'h0ba01c1, 28'h0bb03f0, 28'h2790000, 28'h37a0000, 28'h28d0019, 28'h288e800,
    28'h0fc020e, 28'h0fd01c9};
  localparam logic [7:0] FSV [6] = '{8'h13, 8'h14, 8'h39, 8'h64, 8'h65, 8'hff};
  localparam logic [11:0] MV [9] = '{12'd0, 12'd95, 12'd169, 12'd277, 12'd378, 12'd479,
    12'd580, 12'd703, 12'd1181};
  assign sda_w = !((sda_oe && !sda_out) || host_low);
  pmc_command_map pmc_command_map_i (.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_output_out(alert_out),
    .alert_output_oe(alert_oe), .freq_strap_pin_mv(strap_mv), .freq_from_register(ffr),
    .switching_freq_khz(freq), .operation_control(opctl));
  pmc_host_model pmc_host_model_i (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl),
    .sda_low(host_low));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic xf(input logic [7:0] cc, input int nn, input logic r);
    pmc_host_model_i.xfer(dev_ad, cc, nn, r, d, ack);
    pmc_host_model_i.cyc(3);
  endtask
  task automatic wr(input logic [7:0] cc, input int nn, input logic [15:0] vv);
    d = vv;
    xf(cc, nn, 1'b0);
  endtask
  task automatic chk_reg(input logic [7:0] cc, input int nn);
    d = 16'h0000;
    xf(cc, nn, 1'b1);
    cmp_bit(ack, 1'b1);
    cmp(d, mem[cc]);
  endtask
  task automatic fault(input logic [7:0] bits);
    cmp_bit(alert_oe, 1'b1);
    mem[8'h7e] = {8'h00, bits};
    mem[8'h78] = 16'h0002;
    chk_reg(8'h7e, 1);
    chk_reg(8'h78, 1);
    wr(8'h03, 0, 16'h0000);
    cmp_bit(alert_oe, 1'b0);
    mem[8'h7e] = 16'h0000;
    mem[8'h78] = 16'h0000;
    chk_reg(8'h7e, 1);
  endtask
  function automatic logic [15:0] fs_reg(input logic [7:0] cc);
    int k;
    k = cc * 10;
    if (k < 200) k = 200;
    if (k > 1000) k = 1000;
    return k[15:0];
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end
  initial begin
    seed = 63;
    failures = 0;
    n_compared = 0;
    rst = 1'b1;
    ffr = 1'b1;
    strap_mv = 12'd0;
    dev_ad = 7'h27;
    foreach (TBL[i]) mem[TBL[i][23:16]] = TBL[i][15:0];
    mem[8'hd8] = 16'h008f;
    mem[8'h7e] = 16'h0000;
    mem[8'h78] = 16'h0000;
    repeat (12) @(posedge clk_sys);
    #1 rst = 1'b0;
    pmc_host_model_i.cyc(6);
    cmp({8'h00, opctl}, 16'h0080);
    cmp({6'h00, freq}, fs_reg(8'hb2));
    chk_reg(8'hd8, 1);
    foreach (TBL[i]) begin
      c = TBL[i][23:16];
      n = TBL[i][24] ? 1 : 2;
      chk_reg(c, n);
      v = 16'($random(seed));
      if (n == 1) v[15:8] = 8'h00;
      wr(c, n, v);
      if (TBL[i][25]) begin
        fault(8'h40);
      end else begin
        cmp_bit(ack, 1'b1);
        mem[c] = v;
        chk_reg(c, n);
      end
      if (c == 8'h01) cmp({8'h00, opctl}, mem[c]);
    end
    foreach (FSV[i]) begin
      wr(8'hd2, 1, {8'h00, FSV[i]});
      cmp({6'h00, freq}, fs_reg(FSV[i]));
    end
    c = 8'd20 + 8'($unsigned($random(seed)) % 81);
    wr(8'hd2, 1, {8'h00, c});
    mem[8'hd2] = {8'h00, c};
    cmp({6'h00, freq}, fs_reg(c));
    ffr = 1'b0;
    foreach (MV[i]) begin
      strap_mv = MV[i];
      pmc_host_model_i.cyc(6);
      cmp({6'h00, freq}, 16'(200 + 100 * i));
    end
    ffr = 1'b1;
    wr(8'h02, 0, 16'h0000);
    cmp_bit(ack, 1'b0);
    fault(8'h80);
    wr(8'h01, 2, 16'h1234);
    fault(8'h40);
    chk_reg(8'h01, 1);
    d = 16'h0000;
    xf(8'h01, 2, 1'b1);
    cmp(d, {8'hff, mem[8'h01][7:0]});
    fault(8'h40);
    d = 16'h0000;
    xf(8'h21, 1, 1'b1);
    cmp(d, {8'h00, mem[8'h21][7:0]});
    fault(8'h40);
    ack = 1'b1;
    pmc_host_model_i.start();
    pmc_host_model_i.put_byte({dev_ad, 1'b1}, ack);
    pmc_host_model_i.stop();
    pmc_host_model_i.cyc(3);
    cmp_bit(ack, 1'b0);
    fault(8'h02);
    v = 16'($random(seed));
    wr(8'h21, 2, v);
    mem[8'h21] = v;
    wr(8'h15, 0, 16'h0000);
    cmp_bit(ack, 1'b1);
    wr(8'h21, 2, ~v);
    wr(8'h16, 0, 16'h0000);
    chk_reg(8'h21, 2);
    pmc_host_model_i.xfer(7'h26, 8'h01, 1, 1'b1, d, ack);
    cmp_bit(ack, 1'b0);
    pmc_host_model_i.xfer(7'h07, 8'h01, 1, 1'b1, d, ack);
    cmp_bit(ack, 1'b0);
    wr(8'hd8, 1, 16'h0088);
    dev_ad = 7'h20;
    mem[8'hd8] = 16'h0088;
    chk_reg(8'hd8, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
